// *** logic/rtcsv_pkg.sv ***
// Constants shared by the supervisor: register map, bit positions, reset values, timing.
// Assumes a 50 MHz system clock; all pin inputs arrive asynchronously.
`default_nettype none
package rtcsv_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_WDOG = 8'h09;
    localparam logic [7:0] ADDR_AMON = 8'h0A;
    localparam logic [7:0] ADDR_ADATE = 8'h0B;
    localparam logic [7:0] ADDR_AHOUR = 8'h0C;
    localparam logic [7:0] ADDR_AMIN = 8'h0D;
    localparam logic [7:0] ADDR_ASEC = 8'h0E;
    localparam logic [7:0] ADDR_FLAGS = 8'h0F;
    localparam logic [7:0] ADDR_SQW = 8'h13;
    // Bit positions
    localparam int BIT_OUT = 7;
    localparam int BIT_FT = 6;
    localparam int BIT_AFE = 7;
    localparam int BIT_SQUARE_ENABLE = 6;
    localparam int BIT_ABE = 5;
    localparam int BIT_WDS = 7;
    localparam int BIT_RPT = 7;
    localparam int BIT_RPT5 = 6;
    localparam int BIT_FT_DIV = 6;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h80;
    localparam logic [7:0] REG_ZERO = 8'h00;
    localparam logic [4:0] SYNC_RST = 5'h06;
    // Alarm repeat codes, ordered {alarm_repeat_code}
    localparam logic [4:0] RPT_SEC = 5'h1F;
    localparam logic [4:0] RPT_MIN = 5'h1E;
    localparam logic [4:0] RPT_HOUR = 5'h1C;
    localparam logic [4:0] RPT_DAY = 5'h18;
    localparam logic [4:0] RPT_MONTH = 5'h10;
    localparam logic [4:0] RPT_YEAR = 5'h00;
    // Timebase: phase accumulator producing 65536 Hz ticks
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned CLK_MHZ = 50;
    localparam logic [26:0] ACC_STEP = 27'h0010000;
    localparam logic [26:0] ACC_MOD = 27'h2FAF080;
    localparam int DIV_W = 18;
    localparam int REC_W = 23;
    // Times as printed, then derived cycle counts
    localparam int unsigned T_FAST_NS = 200;
    localparam int unsigned T_SLOW_MS = 100;
    localparam int unsigned T_REC_LONG_MS = 96;
    localparam int unsigned T_REC_ST_MS = 40;
    localparam int unsigned T_REC_SHORT_US = 50;
    localparam int unsigned CYC_FAST = (T_FAST_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CYC_SLOW = T_SLOW_MS * (CLK_HZ / 1000);
    localparam int unsigned CYC_REC_LONG = T_REC_LONG_MS * (CLK_HZ / 1000);
    localparam int unsigned CYC_REC_ST = T_REC_ST_MS * (CLK_HZ / 1000);
    localparam int unsigned CYC_REC_SHORT = T_REC_SHORT_US * CLK_MHZ;
    // Reset output sequencer
    typedef enum logic [1:0] {
        RS_RUN = 2'h0,
        RS_HOLD = 2'h1,
        RS_RECOVER = 2'h3
    } rtcsv_rst_state_t;
endpackage
`default_nettype wire

// *** logic/rtcsv_pulse_qual.sv ***
// Low-pulse qualifier for one reset input: passes a low only once it has lasted CNT cycles.
// Assumes the input is already synchronised to i_clk.
`default_nettype none
module rtcsv_pulse_qual #(
    parameter int unsigned CNT = 10,
    parameter int W = 23
) (
    // Clock and control
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Level in, qualified level out
    input wire logic i_low,
    output logic o_qual
);
    localparam logic [W-1:0] CNT_C = W'(CNT);
    logic [W-1:0] cnt_reg, cnt_next;
    logic qual_reg, qual_next;

    // Saturating count of consecutive low cycles; a short glitch restarts it
    always_comb begin
        cnt_next = '0;
        if (i_low) begin
            cnt_next = (cnt_reg == CNT_C) ? cnt_reg : cnt_reg + 1'b1;
        end
        qual_next = i_low && (cnt_next == CNT_C);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt_reg <= '0;
            qual_reg <= 1'b0;
        end else if (i_ce) begin
            cnt_reg <= cnt_next;
            qual_reg <= qual_next;
        end
    end

    assign o_qual = qual_reg;
endmodule
`default_nettype wire

// *** logic/rtcsv_top.sv ***
// Alarm, watchdog, square wave and reset supervisor of a serial clock device.
// Assumes a bus engine delivering decoded register strobes and the live pointer,
// and timekeeping logic pulsing i_time_tick on each BCD field update.
`default_nettype none
module rtcsv_top
    import rtcsv_pkg::*;
#(
    parameter int unsigned P_SLOW_CYC = CYC_SLOW,
    parameter int unsigned P_REC_LONG_CYC = CYC_REC_LONG,
    parameter int unsigned P_REC_ST_CYC = CYC_REC_ST
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Register port from the serial engine
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] i_reg_ptr,
    output logic [7:0] o_reg_rdata,
    // Clock fields and status from timekeeping
    input wire logic i_time_tick,
    input wire logic [6:0] i_time_sec,
    input wire logic [6:0] i_time_min,
    input wire logic [5:0] i_time_hour,
    input wire logic [5:0] i_time_date,
    input wire logic [4:0] i_time_month,
    input wire logic i_oscillator_halt_bit,
    input wire logic i_recovery_select_bit,
    input wire logic i_battery_low,
    // Asynchronous pins
    input wire logic i_watchdog_kick_input,
    input wire logic i_reset_input_fast_n,
    input wire logic i_reset_input_slow_n,
    input wire logic i_power_fail,
    input wire logic i_battery_mode,
    // Open-drain and push-pull outputs
    output logic o_interrupt_test_pin_o,
    output logic o_interrupt_test_pin_oe,
    output logic o_reset_pin_o,
    output logic o_reset_pin_oe,
    output logic o_square_wave_pin
);
    localparam logic [REC_W-1:0] REC_LONG_C = REC_W'(P_REC_LONG_CYC);
    localparam logic [REC_W-1:0] REC_ST_C = REC_W'(P_REC_ST_CYC);
    localparam logic [REC_W-1:0] REC_SHORT_C = REC_W'(CYC_REC_SHORT);

    // Two-flop synchronisers, bit order {battery, power fail, slow, fast, kick}
    logic [4:0] pin_raw, sync1_reg, sync2_reg;
    assign pin_raw = {i_battery_mode, i_power_fail, i_reset_input_slow_n,
                      i_reset_input_fast_n, i_watchdog_kick_input};
    for (genvar g = 0; g < 5; g++) begin : g_sync
        always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
                sync1_reg[g] <= SYNC_RST[g];
                sync2_reg[g] <= SYNC_RST[g];
            end else if (i_ce) begin
                sync1_reg[g] <= pin_raw[g];
                sync2_reg[g] <= sync1_reg[g];
            end
        end
    end
    logic bat_s, pf_s, fast_q, slow_q;
    assign bat_s = sync2_reg[4];
    assign pf_s = sync2_reg[3];

    // Glitch filters on both reset inputs
    rtcsv_pulse_qual #(.CNT(CYC_FAST), .W(REC_W)) u_fast (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .i_low(!sync2_reg[1]), .o_qual(fast_q));
    rtcsv_pulse_qual #(.CNT(P_SLOW_CYC), .W(REC_W)) u_slow (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .i_low(!sync2_reg[2]), .o_qual(slow_q));

    // Timebase: 65536 Hz tick and binary divider
    logic [25:0] acc_reg, acc_next;
    logic [DIV_W-1:0] div_reg, div_next;
    logic [26:0] acc_sum, acc_sub;
    logic tb_tick;
    assign acc_sum = {1'b0, acc_reg} + ACC_STEP;
    assign acc_sub = acc_sum - ACC_MOD;
    assign tb_tick = (acc_sum >= ACC_MOD);
    always_comb begin
        acc_next = tb_tick ? acc_sub[25:0] : acc_sum[25:0];
        div_next = tb_tick ? div_reg + 1'b1 : div_reg;
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            acc_reg <= '0;
            div_reg <= '0;
        end else if (i_ce) begin
            acc_reg <= acc_next;
            div_reg <= div_next;
        end
    end

    // Host-visible and supervisory state
    logic [7:0] ctrl_reg, ctrl_next, wdog_reg, wdog_next, amon_reg, amon_next;
    logic [7:0] adate_reg, adate_next, ahour_reg, ahour_next;
    logic [7:0] amin_reg, amin_next, asec_reg, asec_next, sqw_reg, sqw_next;
    logic [7:0] rdata_reg, rdata_next;
    logic af_reg, af_next, wdf_reg, wdf_next, alarm_irq_reg, alarm_irq_next;
    logic wd_irq_reg, wd_irq_next, wd_stop_reg, wd_stop_next, kick_d_reg, kick_d_next;
    logic irq_oe_reg, irq_oe_next, sqw_out_reg, sqw_out_next;
    logic [4:0] wd_cnt_reg, wd_cnt_next;

    logic [4:0] rpt, wd_mult;
    logic [1:0] wd_res;
    logic watchdog_steering, afe, abe, square_enable, ft, res_tick, kick_edge, wr_wdog, restart, wd_timeout;
    logic rd_flags, n_sec, n_min, n_hour, n_date, n_mon, alarm_hit, alarm_drive;
    logic ft_mode, idle_mode;
    logic [3:0] rate;

    assign rpt = {adate_reg[BIT_RPT5], adate_reg[BIT_RPT], ahour_reg[BIT_RPT],
                  amin_reg[BIT_RPT], asec_reg[BIT_RPT]};
    assign watchdog_steering = wdog_reg[BIT_WDS];
    assign wd_mult = wdog_reg[6:2];
    assign wd_res = wdog_reg[1:0];
    assign afe = amon_reg[BIT_AFE];
    assign abe = amon_reg[BIT_ABE];
    assign square_enable = amon_reg[BIT_SQUARE_ENABLE];
    assign ft = ctrl_reg[BIT_FT];
    assign rate = sqw_reg[7:4];
    assign kick_edge = sync2_reg[0] ^ kick_d_reg;
    assign wr_wdog = i_reg_wr && (i_reg_addr == ADDR_WDOG);
    assign rd_flags = i_reg_rd && (i_reg_addr == ADDR_FLAGS);
    assign restart = kick_edge || wr_wdog;

    // Resolution tick at 1/16, 1/4, 1 or 4 s
    always_comb begin
        case (wd_res)
            2'h0: res_tick = tb_tick && (&div_reg[11:0]);
            2'h1: res_tick = tb_tick && (&div_reg[13:0]);
            2'h2: res_tick = tb_tick && (&div_reg[15:0]);
            default: res_tick = tb_tick && (&div_reg[17:0]);
        endcase
    end
    // A restart in the expiry cycle wins, so a late kick still rescues the host
    assign wd_timeout = res_tick && (wd_mult != 5'h00) && !wd_stop_reg && !restart &&
                        (({1'b0, wd_cnt_reg} + 6'h01) == {1'b0, wd_mult});

    // Field masks per repeat mode; unknown codes fall to every second
    always_comb begin
        {n_sec, n_min, n_hour, n_date, n_mon} = 5'h00;
        case (rpt)
            RPT_MIN: n_sec = 1'b1;
            RPT_HOUR: {n_sec, n_min} = 2'h3;
            RPT_DAY: {n_sec, n_min, n_hour} = 3'h7;
            RPT_MONTH: {n_sec, n_min, n_hour, n_date} = 4'hF;
            RPT_YEAR: {n_sec, n_min, n_hour, n_date, n_mon} = 5'h1F;
            default: {n_sec, n_min, n_hour, n_date, n_mon} = 5'h00;
        endcase
    end
    // Compared only on the update pulse so one match raises one event
    assign alarm_hit = i_time_tick &&
        (!n_sec || (asec_reg[6:0] == i_time_sec)) &&
        (!n_min || (amin_reg[6:0] == i_time_min)) &&
        (!n_hour || (ahour_reg[5:0] == i_time_hour)) &&
        (!n_date || (adate_reg[5:0] == i_time_date)) &&
        (!n_mon || (amon_reg[4:0] == i_time_month));
    assign alarm_drive = alarm_irq_reg && (i_reg_ptr != ADDR_FLAGS);
    assign ft_mode = ft && !i_oscillator_halt_bit && !afe &&
                     (watchdog_steering || (wdog_reg == REG_ZERO));
    assign idle_mode = !ft && !afe && (wdog_reg == REG_ZERO);

    // Next-state for registers, flags, watchdog and pins
    always_comb begin
        ctrl_next = ctrl_reg;
        wdog_next = wdog_reg;
        amon_next = amon_reg;
        adate_next = adate_reg;
        ahour_next = ahour_reg;
        amin_next = amin_reg;
        asec_next = asec_reg;
        sqw_next = sqw_reg;
        af_next = af_reg;
        wdf_next = wdf_reg;
        alarm_irq_next = alarm_irq_reg;
        wd_irq_next = wd_irq_reg;
        wd_stop_next = wd_stop_reg;
        wd_cnt_next = wd_cnt_reg;
        kick_d_next = sync2_reg[0];
        rdata_next = rdata_reg;
        if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_CTRL: ctrl_next = i_reg_wdata;
                ADDR_WDOG: wdog_next = i_reg_wdata;
                ADDR_AMON: amon_next = i_reg_wdata;
                ADDR_ADATE: adate_next = i_reg_wdata;
                ADDR_AHOUR: ahour_next = i_reg_wdata;
                ADDR_AMIN: amin_next = i_reg_wdata;
                ADDR_ASEC: asec_next = i_reg_wdata;
                ADDR_SQW: sqw_next = {i_reg_wdata[7:4], 4'h0};
                default: ;
            endcase
        end
        // Watchdog count
        if (restart) begin
            wd_cnt_next = 5'h00;
            wd_stop_next = 1'b0;
            if (wr_wdog && (i_reg_wdata == REG_ZERO)) begin
                wd_irq_next = 1'b0;
            end
        end else if (res_tick && !wd_stop_reg && (wd_mult != 5'h00)) begin
            wd_cnt_next = wd_cnt_reg + 5'h01;
        end
        // Flag reads clear first; hardware sets below take precedence
        if (rd_flags) begin
            af_next = 1'b0;
            alarm_irq_next = 1'b0;
            wdf_next = 1'b0;
        end
        if (wd_timeout) begin
            wdf_next = 1'b1;
            wd_cnt_next = 5'h00;
            if (watchdog_steering) begin
                wdog_next = REG_ZERO;
                ctrl_next[BIT_FT] = 1'b0;
                amon_next[BIT_AFE] = 1'b0;
                amon_next[BIT_ABE] = 1'b0;
                amon_next[BIT_SQUARE_ENABLE] = 1'b0;
            end else begin
                wd_irq_next = 1'b1;
                wd_stop_next = 1'b1;
            end
        end
        if (alarm_hit) begin
            af_next = 1'b1;
            if (afe && (!bat_s || abe)) begin
                alarm_irq_next = 1'b1;
            end
        end
        // Read data captured before the clear, so the cleared flag shows next read
        if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_CTRL: rdata_next = ctrl_reg;
                ADDR_WDOG: rdata_next = wdog_reg;
                ADDR_AMON: rdata_next = amon_reg;
                ADDR_ADATE: rdata_next = adate_reg;
                ADDR_AHOUR: rdata_next = ahour_reg;
                ADDR_AMIN: rdata_next = amin_reg;
                ADDR_ASEC: rdata_next = asec_reg;
                ADDR_FLAGS: rdata_next = {wdf_reg, af_reg, 1'b0, i_battery_low, 4'h0};
                ADDR_SQW: rdata_next = sqw_reg;
                default: rdata_next = REG_ZERO;
            endcase
        end
        // Interrupt pin: pending events, then test tone, then level bit
        if (wd_irq_reg || alarm_drive) begin
            irq_oe_next = 1'b1;
        end else if (ft_mode) begin
            irq_oe_next = !div_reg[BIT_FT_DIV];
        end else if (idle_mode) begin
            irq_oe_next = !ctrl_reg[BIT_OUT];
        end else begin
            irq_oe_next = 1'b0;
        end
        // Square wave: code 1 uses divider bit 0, higher codes use bit = code
        if (!square_enable || (rate == 4'h0)) begin
            sqw_out_next = 1'b0;
        end else if (rate == 4'h1) begin
            sqw_out_next = div_reg[0];
        end else begin
            sqw_out_next = div_reg[rate];
        end
    end

    // Power-up clears enables and watchdog; the level bit comes up set
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl_reg <= CTRL_RST;
            wdog_reg <= REG_ZERO;
            amon_reg <= REG_ZERO;
            adate_reg <= REG_ZERO;
            ahour_reg <= REG_ZERO;
            amin_reg <= REG_ZERO;
            asec_reg <= REG_ZERO;
            sqw_reg <= REG_ZERO;
            rdata_reg <= REG_ZERO;
            af_reg <= 1'b0;
            wdf_reg <= 1'b0;
            alarm_irq_reg <= 1'b0;
            wd_irq_reg <= 1'b0;
            wd_stop_reg <= 1'b0;
            wd_cnt_reg <= 5'h00;
            kick_d_reg <= 1'b0;
            irq_oe_reg <= 1'b0;
            sqw_out_reg <= 1'b0;
        end else if (i_ce) begin
            ctrl_reg <= ctrl_next;
            wdog_reg <= wdog_next;
            amon_reg <= amon_next;
            adate_reg <= adate_next;
            ahour_reg <= ahour_next;
            amin_reg <= amin_next;
            asec_reg <= asec_next;
            sqw_reg <= sqw_next;
            rdata_reg <= rdata_next;
            af_reg <= af_next;
            wdf_reg <= wdf_next;
            alarm_irq_reg <= alarm_irq_next;
            wd_irq_reg <= wd_irq_next;
            wd_stop_reg <= wd_stop_next;
            wd_cnt_reg <= wd_cnt_next;
            kick_d_reg <= kick_d_next;
            irq_oe_reg <= irq_oe_next;
            sqw_out_reg <= sqw_out_next;
        end
    end

    // Reset output sequencer
    rtcsv_rst_state_t rs_state_reg, rs_state_next;
    logic [REC_W-1:0] rec_cnt_reg, rec_cnt_next, rec_len;
    logic rst_oe_reg, rst_oe_next, rst_src;
    assign rst_src = pf_s || fast_q || slow_q;
    assign rec_len = i_recovery_select_bit ? REC_SHORT_C :
                     (i_oscillator_halt_bit ? REC_ST_C : REC_LONG_C);
    always_comb begin
        rs_state_next = rs_state_reg;
        rec_cnt_next = rec_cnt_reg;
        case (rs_state_reg)
            RS_RUN: begin
                if (rst_src) begin
                    rs_state_next = RS_HOLD;
                end else if (wd_timeout && watchdog_steering) begin
                    rs_state_next = RS_RECOVER;
                    rec_cnt_next = rec_len - 1'b1;
                end
            end
            RS_HOLD: begin
                if (!rst_src) begin
                    rs_state_next = RS_RECOVER;
                    rec_cnt_next = rec_len - 1'b1;
                end
            end
            RS_RECOVER: begin
                if (rst_src) begin
                    rs_state_next = RS_HOLD;
                end else if (rec_cnt_reg == '0) begin
                    rs_state_next = RS_RUN;
                end else begin
                    rec_cnt_next = rec_cnt_reg - 1'b1;
                end
            end
            default: rs_state_next = RS_HOLD;
        endcase
        rst_oe_next = (rs_state_next != RS_RUN);
    end
    // Comes out of reset driving low: the host sees a clean reset after power-up
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rs_state_reg <= RS_RECOVER;
            rec_cnt_reg <= REC_SHORT_C;
            rst_oe_reg <= 1'b1;
        end else if (i_ce) begin
            rs_state_reg <= rs_state_next;
            rec_cnt_reg <= rec_cnt_next;
            rst_oe_reg <= rst_oe_next;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_interrupt_test_pin_o = 1'b0;
    assign o_interrupt_test_pin_oe = irq_oe_reg;
    assign o_reset_pin_o = 1'b0;
    assign o_reset_pin_oe = rst_oe_reg;
    assign o_square_wave_pin = sqw_out_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence wd_rst_fire;
        i_ce && wd_timeout && watchdog_steering;
    endsequence
    sequence wd_rst_done;
        (rs_state_reg != RS_RUN) && (wdog_reg == REG_ZERO) && !afe && !square_enable && !ft;
    endsequence
    minute_mode_a: assert property (i_ce && i_time_tick && rpt == RPT_MIN &&
        asec_reg[6:0] == i_time_sec |=> af_reg) else $error("minute alarm missed");
    bad_code_a: assert property (i_ce && i_time_tick && rpt == 5'h0F
        |=> af_reg) else $error("odd repeat code not every second");
    alarm_pin_a: assert property (i_ce && alarm_irq_reg && i_reg_ptr != ADDR_FLAGS
        |=> o_interrupt_test_pin_oe) else $error("alarm pin not driven");
    flag_clear_a: assert property (i_ce && rd_flags && !alarm_hit && !wd_timeout
        |=> !af_reg && !alarm_irq_reg && !wdf_reg) else $error("flags read did not clear");
    bat_gate_a: assert property (i_ce && alarm_hit && bat_s && !abe
        |=> !$rose(alarm_irq_reg)) else $error("battery alarm without enable");
    wd_flag_a: assert property (i_ce && wd_timeout |=> wdf_reg)
        else $error("watchdog flag not set");
    wd_reset_a: assert property (wd_rst_fire |=> wd_rst_done)
        else $error("reset-steered timeout effects missing");
    wd_kick_a: assert property (i_ce && kick_edge |=> wd_cnt_reg == 5'h00)
        else $error("kick did not restart watchdog");
    wd_hold_a: assert property (i_ce && wd_timeout && !watchdog_steering
        |=> wd_stop_reg && wd_irq_reg ##1 (!i_ce || o_interrupt_test_pin_oe))
        else $error("interrupt-steered timeout wrong");
    sqw_off_a: assert property (i_ce && !square_enable |=> !o_square_wave_pin)
        else $error("square wave while disabled");
    pf_hold_a: assert property (i_ce && pf_s |=> o_reset_pin_oe [*2])
        else $error("reset released during power fail");
endmodule
`default_nettype wire

// *** tb/rtcsv_host.sv ***
// Host-side model: pull-ups on the open-drain pins, kick line.
// Assumes high pull-down enables from the supervisor.
`default_nettype none
module rtcsv_host (
    // Clock and requests
    input wire logic i_clk,
    input wire logic i_kick_req,
    // Pull-down enables
    input wire logic i_irq_oe,
    input wire logic i_rst_oe,
    // Pin levels
    output logic o_irq_level,
    output logic o_rst_level,
    output var logic o_kick = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up wins unless a driver pulls low
    assign o_irq_level = ~i_irq_oe;
    assign o_rst_level = ~i_rst_oe;
    // Either kick edge restarts, so one toggle per request
    always @(posedge i_clk) if (i_kick_req) o_kick <= ~o_kick;
endmodule
`default_nettype wire

// *** tb/rtcsv_top_tb.sv ***
// Bench for the supervisor: registers, alarm pin, square wave, reset out.
// Assumes shortened recovery counts and the host pull-up model.
`default_nettype none
module rtcsv_top_tb import rtcsv_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst = 1'b1, wr = 1'b0, rd = 1'b0, tick = 1'b0, kreq = 1'b0;
    logic fast_n = 1'b1, slow_n = 1'b1, pfail = 1'b0, tr = 1'b0, st = 1'b0;
    logic blow = 1'b1, bmode = 1'b0, irq_oe, rst_oe, square_wave_rate, irq_lv, rst_lv, kick;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ptr = 8'h00, rdata;
    logic [6:0] sec = 7'h00;
    logic [4:0] fld = 5'h00;
    int fails = 0, cmp_count = 0, t;
    rtcsv_top #(.P_SLOW_CYC(50), .P_REC_LONG_CYC(60), .P_REC_ST_CYC(40)) rtcsv_top_inst (
        .i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_ptr(ptr), .o_reg_rdata(rdata),
        .i_time_tick(tick), .i_time_sec(sec), .i_time_min(sec), .i_time_hour({1'b0, fld}),
        .i_time_date({1'b0, fld}), .i_time_month(fld), .i_oscillator_halt_bit(st),
        .i_recovery_select_bit(tr), .i_battery_low(blow), .i_watchdog_kick_input(kick),
        .i_reset_input_fast_n(fast_n), .i_reset_input_slow_n(slow_n), .i_power_fail(pfail),
        .i_battery_mode(bmode), .o_interrupt_test_pin_o(), .o_interrupt_test_pin_oe(irq_oe),
        .o_reset_pin_o(), .o_reset_pin_oe(rst_oe), .o_square_wave_pin(square_wave_rate));
    rtcsv_host rtcsv_host_inst (.i_clk(clk), .i_kick_req(kreq), .i_irq_oe(irq_oe),
        .i_rst_oe(rst_oe), .o_irq_level(irq_lv), .o_rst_level(rst_lv), .o_kick(kick));
    // Byte compare; pin levels go through it zero-extended
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {wr, addr, wdata} = {1'b1, a, d};
        @(negedge clk);
        wr = 1'b0;
    endtask
    // Data lands one cycle after the strobe edge
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        {rd, addr} = {1'b1, a};
        @(negedge clk);
        rd = 1'b0;
        chk("rdata", e, rdata);
    endtask
    task automatic sqw_count(input int n);
        logic p;
        t = 0;
        p = square_wave_rate;
        repeat (n) begin
            @(negedge clk);
            if (square_wave_rate !== p) t++;
            p = square_wave_rate;
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Whole run is near 9000 cycles
    initial begin
        #400us;
        fails++;
        print_verdict();
    end
    initial begin
        cyc(3);
        rst = 1'b0;
        rreg(ADDR_CTRL, CTRL_RST);
        rreg(ADDR_WDOG, REG_ZERO);
        rreg(ADDR_AMON, REG_ZERO);
        rreg(ADDR_FLAGS, 8'h10);
        chk("irq_pin", 8'h01, {7'h0, irq_lv});
        wreg(ADDR_CTRL, 8'h00);
        cyc(3);
        chk("irq_pin", 8'h00, {7'h0, irq_lv});
        wreg(ADDR_CTRL, CTRL_RST);
        wreg(ADDR_WDOG, 8'h8F);
        kreq = 1'b1;
        cyc(1);
        kreq = 1'b0;
        rreg(ADDR_WDOG, 8'h8F);
        wreg(ADDR_WDOG, REG_ZERO);
        wreg(ADDR_SQW, 8'h15);
        rreg(ADDR_SQW, 8'h10);
        sqw_count(3000);
        chk("sqw_off", 8'h00, t[7:0]);
        // Every-minute alarm with seconds at 25, pointer parked on flags
        for (int i = 0; i < 4; i++) wreg(ADDR_AMON + 8'(i), (i < 2) ? 8'hC0 : 8'h80);
        wreg(ADDR_ASEC, 8'h25);
        sqw_count(3000);
        chk("sqw_on", 8'h01, {7'h0, t == 3 || t == 4});
        {ptr, sec, fld} = {ADDR_FLAGS, 7'h25, 5'h07};
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(4);
        chk("irq_pin", 8'h01, {7'h0, irq_lv});
        ptr = 8'h00;
        cyc(3);
        chk("irq_pin", 8'h00, {7'h0, irq_lv});
        rreg(ADDR_FLAGS, 8'h50);
        cyc(2);
        chk("irq_pin", 8'h01, {7'h0, irq_lv});
        rreg(ADDR_FLAGS, 8'h10);
        // Backup mode without the battery enable: flag only, pin stays released
        bmode = 1'b1;
        cyc(3);
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(3);
        chk("irq_pin", 8'h01, {7'h0, irq_lv});
        rreg(ADDR_FLAGS, 8'h50);
        bmode = 1'b0;
        // Once-a-year mode: date and every repeat bit zero, minute 00 misses 25, no further flag
        wreg(ADDR_ADATE, REG_ZERO);
        wreg(ADDR_AHOUR, REG_ZERO);
        wreg(ADDR_AMIN, REG_ZERO);
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(2);
        rreg(ADDR_FLAGS, 8'h10);
        chk("rst_pin", 8'h01, {7'h0, rst_lv});
        fast_n = 1'b0;
        cyc(5);
        fast_n = 1'b1;
        cyc(20);
        chk("rst_pin", 8'h01, {7'h0, rst_lv});
        fast_n = 1'b0;
        cyc(15);
        chk("rst_pin", 8'h00, {7'h0, rst_lv});
        fast_n = 1'b1;
        cyc(55);
        chk("rst_pin", 8'h00, {7'h0, rst_lv});
        cyc(15);
        chk("rst_pin", 8'h01, {7'h0, rst_lv});
        {st, slow_n} = 2'b10;
        cyc(40);
        chk("rst_pin", 8'h01, {7'h0, rst_lv});
        cyc(20);
        chk("rst_pin", 8'h00, {7'h0, rst_lv});
        slow_n = 1'b1;
        cyc(35);
        chk("rst_pin", 8'h00, {7'h0, rst_lv});
        cyc(15);
        chk("rst_pin", 8'h01, {7'h0, rst_lv});
        {pfail, tr} = 2'b11;
        cyc(6);
        chk("rst_pin", 8'h00, {7'h0, rst_lv});
        pfail = 1'b0;
        cyc(2400);
        chk("rst_pin", 8'h00, {7'h0, rst_lv});
        cyc(150);
        chk("rst_pin", 8'h01, {7'h0, rst_lv});
        print_verdict();
    end
endmodule
`default_nettype wire
